/* File: cer_defs.svh */
// offsets, field positions, reset values and timing counts of the camera effect register bank
`ifndef CER_DEFS_SVH
`define CER_DEFS_SVH

// register indices; byte address is four times the index
`define CER_IDX_EFFECT   8'h79
`define CER_IDX_EEPROM   8'h80
`define CER_IDX_STROBE_ACTIVE_TIME_LO  8'h94
`define CER_IDX_STROBE_ACTIVE_TIME_MID 8'h95
`define CER_IDX_STROBE_ACTIVE_TIME_HI  8'h96
`define CER_IDX_PDC_MODE 8'hA0
`define CER_IDX_PDC_SEL  8'hA1
`define CER_IDX_WX_LO    8'hA2
`define CER_IDX_WX_HI    8'hA3
`define CER_IDX_WY_LO    8'hA4
`define CER_IDX_WY_HI    8'hA5
`define CER_IDX_RX_LO    8'hA6
`define CER_IDX_RX_HI    8'hA7
`define CER_IDX_RY_LO    8'hA8
`define CER_IDX_RY_HI    8'hA9

// field positions
`define CER_EFF_NEG      7
`define CER_E2P_WREN     0
`define CER_E2P_SYNC     1
`define CER_PDC_WRIDX    7
`define CER_PDC_RDIDX    6
`define CER_PDC_SAVE     5
`define CER_PDC_SHOW     1
`define CER_PDC_EN       0
`define CER_EFF_MAXCODE  6'h0B

// reset values
`define CER_RST_EFFECT   8'h00
`define CER_RST_EEPROM   2'h0
`define CER_RST_STROBE_ACTIVE_TIME     24'h000000
`define CER_RST_PDC      8'h00
`define CER_LAST_INDEX   4'hF

// timing: one microsecond in clock cycles of the 10 ns clock
`define CER_CLK_NS       10
`define CER_US_NS        1000
`define CER_CYC_PER_US   (`CER_US_NS / `CER_CLK_NS)

`endif

/* File: cer_ee_model.sv */
// eeprom-side model taking the index save stream with stalls
`timescale 1ns/1ns
`default_nettype none

module cer_ee_model (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // save stream
  input  wire cer_pkg::cer_save_t ee_save,
  output logic                    ee_save_ready,
  // observation
  output int                      rec_cnt,
  output int                      bad_cnt
);
  import cer_pkg::*;
  // ready alternates; against the writer's two-cycle record loop only the first take can stall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ee_save_ready <= 1'b0;
      rec_cnt       <= 0;
      bad_cnt       <= 0;
    end else begin
      ee_save_ready <= ~ee_save_ready;
      if (ee_save.valid && ee_save_ready) begin
        rec_cnt <= rec_cnt + 1;
        if (ee_save.index !== rec_cnt[3:0]) begin
          bad_cnt <= bad_cnt + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: cer_index_mem.sv */
// sixteen-entry store of defect coordinates with registered read data
`timescale 1ns/1ns
`default_nettype none

module cer_index_mem #(
  parameter int DEPTH = 16
) (
  // clock
  input  wire logic                pclk,
  // write port
  input  wire logic                we,
  input  wire logic [3:0]          waddr,
  input  wire cer_pkg::cer_coord_t wdata,
  // read port
  input  wire logic [3:0]          raddr,
  output cer_pkg::cer_coord_t      rdata
);
  import cer_pkg::*;

  cer_coord_t mem [DEPTH];

  // no reset on the array: contents are only meaningful once written
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule
`default_nettype wire

/* File: cer_pkg.sv */
// types shared by the camera effect register bank and its helpers
package cer_pkg;

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } cer_apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } cer_apb_rsp_t;

  // one pixel of video
  typedef struct packed {
    logic        valid;
    logic [11:0] data;
  } cer_pix_t;

  // one defect coordinate pair
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
  } cer_coord_t;

  // one index record offered to the eeprom writer
  typedef struct packed {
    logic       valid;
    logic [3:0] index;
    cer_coord_t coord;
  } cer_save_t;

  // index transfer sequencer
  typedef enum logic [5:0] {
    CER_IDLE   = 6'b000001,
    CER_WR     = 6'b000010,
    CER_RD     = 6'b000100,
    CER_RD_LD  = 6'b001000,
    CER_SV_RD  = 6'b010000,
    CER_SV_OUT = 6'b100000
  } cer_seq_t;

  // whole state of the register bank
  typedef struct packed {
    logic [7:0]  effect;
    logic [1:0]  e2p;
    logic [23:0] strobe_active_time;
    logic [7:0]  pdc;
    logic [3:0]  idx;
    cer_coord_t  wr;
    cer_coord_t  rd;
    cer_seq_t    seq;
    logic [3:0]  cnt;
    logic [31:0] prdata;
    logic        pslverr;
    logic        load_ack;
    cer_pix_t    pix;
  } cer_state_t;

  // whole state of the strobe timer
  typedef struct packed {
    logic        sync1;
    logic        sync2;
    logic        prev;
    logic [6:0]  pre;
    logic [23:0] left;
    logic        strobe;
  } cer_strobe_active_time_state_t;

endpackage

/* File: cer_regs.sv */
// camera effect, eeprom control, strobe time and defect index register bank
`timescale 1ns/1ns
`default_nettype none
`include "cer_defs.svh"

module cer_regs (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire cer_pkg::cer_apb_req_t apb_req,
  output cer_pkg::cer_apb_rsp_t     apb_rsp,
  // video in and out
  input  wire cer_pkg::cer_pix_t    pix_in,
  output cer_pkg::cer_pix_t         pix_out,
  // defect correction controls
  output logic                      pdc_enable,
  output logic                      pdc_marker_show,
  // eeprom side
  output logic                      ee_write_en,
  output logic                      ee_sync_en,
  input  wire logic                 ee_load_req,
  output logic                      ee_load_ack,
  output cer_pkg::cer_save_t        ee_save,
  input  wire logic                 ee_save_ready,
  // strobe
  input  wire logic                 strobe_trig,
  output logic                      strobe
);
  import cer_pkg::*;

  cer_state_t s_reg;
  cer_state_t s_next;
  cer_coord_t mem_rdata;
  logic       mem_we;
  logic [3:0] mem_raddr;
  logic       setup;
  logic       access;
  logic       busy;
  logic       hit;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic       e2p_wr;

  // split an apb byte address into a register index; misaligned or high
  // addresses are unmapped
  // the hit flag rides above the index so one call feeds both
  function automatic logic [8:0] decode(input logic [11:0] a);
    logic [7:0] i;
    logic       ok;
    i = a[9:2];
    ok = (a[1:0] == 2'b00) && (a[11:10] == 2'b00);
    case (i)
      `CER_IDX_EFFECT, `CER_IDX_EEPROM, `CER_IDX_STROBE_ACTIVE_TIME_LO, `CER_IDX_STROBE_ACTIVE_TIME_MID,
      `CER_IDX_STROBE_ACTIVE_TIME_HI, `CER_IDX_PDC_MODE, `CER_IDX_PDC_SEL, `CER_IDX_WX_LO,
      `CER_IDX_WX_HI, `CER_IDX_WY_LO, `CER_IDX_WY_HI, `CER_IDX_RX_LO,
      `CER_IDX_RX_HI, `CER_IDX_RY_LO, `CER_IDX_RY_HI: begin
        decode = {ok, i};
      end
      default: begin
        decode = {1'b0, i};
      end
    endcase
  endfunction

  // read value of one register; narrow registers sit in the low bits
  function automatic logic [7:0] read_reg(input cer_state_t s, input logic [7:0] i);
    case (i)
      `CER_IDX_EFFECT:   read_reg = {s.effect[7], 1'b0, s.effect[5:0]};
      `CER_IDX_EEPROM:   read_reg = {6'h00, s.e2p};
      `CER_IDX_STROBE_ACTIVE_TIME_LO:  read_reg = s.strobe_active_time[7:0];
      `CER_IDX_STROBE_ACTIVE_TIME_MID: read_reg = s.strobe_active_time[15:8];
      `CER_IDX_STROBE_ACTIVE_TIME_HI:  read_reg = s.strobe_active_time[23:16];
      `CER_IDX_PDC_MODE: read_reg = {s.pdc[7:5], 3'b000, s.pdc[1:0]};
      `CER_IDX_PDC_SEL:  read_reg = {4'h0, s.idx};
      `CER_IDX_WX_LO:    read_reg = s.wr.x[7:0];
      `CER_IDX_WX_HI:    read_reg = s.wr.x[15:8];
      `CER_IDX_WY_LO:    read_reg = s.wr.y[7:0];
      `CER_IDX_WY_HI:    read_reg = s.wr.y[15:8];
      `CER_IDX_RX_LO:    read_reg = s.rd.x[7:0];
      `CER_IDX_RX_HI:    read_reg = s.rd.x[15:8];
      `CER_IDX_RY_LO:    read_reg = s.rd.y[7:0];
      `CER_IDX_RY_HI:    read_reg = s.rd.y[15:8];
      default:           read_reg = 8'h00;
    endcase
  endfunction

  // gradation cut and polarity of one pixel
  function automatic logic [11:0] effect_pix(input logic [11:0] d, input logic [7:0] e);
    logic [11:0] v;
    v = d;
    // codes 0CH and up are prohibited and simply pass unchanged
    if (e[5:0] != 6'h00 && e[5:0] <= `CER_EFF_MAXCODE) begin
      v = d & (12'hFFF << e[3:0]);
    end
    if (e[`CER_EFF_NEG]) begin
      v = ~v;
    end
    effect_pix = v;
  endfunction

  // apb phase decode shared by reads and writes
  assign setup  = apb_req.psel && !apb_req.penable;
  assign access = apb_req.psel && apb_req.penable;
  assign {hit, idx} = decode(apb_req.paddr);
  assign wbyte  = apb_req.pwdata[7:0];
  assign busy   = (s_reg.seq != CER_IDLE);

  // host write to the eeprom control register; its set wins over a self-clear
  assign e2p_wr = access && apb_req.pwrite && hit && (idx == `CER_IDX_EEPROM);

  // memory ports follow the sequencer
  assign mem_we    = (s_reg.seq == CER_WR);
  assign mem_raddr = (s_reg.seq == CER_SV_RD || s_reg.seq == CER_SV_OUT) ? s_reg.cnt : s_reg.idx;

  // next state of the whole bank
  always_comb begin
    s_next          = s_reg;
    s_next.load_ack = 1'b0;

    // read data and error are captured in the setup cycle so the access
    // phase can finish with no wait state
    if (setup) begin
      s_next.prdata  = {24'h000000, read_reg(s_reg, idx)};
      s_next.pslverr = !hit;
    end

    // register writes at the access edge
    // unmapped or read-only places change nothing
    if (access && apb_req.pwrite && hit) begin
      case (idx)
        `CER_IDX_EFFECT: begin
          s_next.effect = {wbyte[7], 1'b0, wbyte[5:0]};
        end
        `CER_IDX_EEPROM: begin
          s_next.e2p = wbyte[1:0];
        end
        `CER_IDX_STROBE_ACTIVE_TIME_LO: begin
          s_next.strobe_active_time[7:0] = wbyte;
        end
        `CER_IDX_STROBE_ACTIVE_TIME_MID: begin
          s_next.strobe_active_time[15:8] = wbyte;
        end
        `CER_IDX_STROBE_ACTIVE_TIME_HI: begin
          s_next.strobe_active_time[23:16] = wbyte;
        end
        `CER_IDX_PDC_MODE: begin
          s_next.pdc[1:0] = wbyte[1:0];
          // one trigger at a time, highest bit first; none while busy
          // a trigger written while busy is lost, not queued
          if (!busy) begin
            if (wbyte[`CER_PDC_WRIDX]) begin
              s_next.pdc[`CER_PDC_WRIDX] = 1'b1;
              s_next.seq = CER_WR;
            end else if (wbyte[`CER_PDC_RDIDX]) begin
              s_next.pdc[`CER_PDC_RDIDX] = 1'b1;
              s_next.seq = CER_RD;
            end else if (wbyte[`CER_PDC_SAVE] && s_reg.e2p[`CER_E2P_WREN]) begin
              s_next.pdc[`CER_PDC_SAVE] = 1'b1;
              s_next.cnt = 4'h0;
              s_next.seq = CER_SV_RD;
            end
          end
        end
        `CER_IDX_PDC_SEL: begin
          // upper bits are dropped and read back as zero
          s_next.idx = wbyte[3:0];
        end
        `CER_IDX_WX_LO: begin
          s_next.wr.x[7:0] = wbyte;
        end
        `CER_IDX_WX_HI: begin
          s_next.wr.x[15:8] = wbyte;
        end
        `CER_IDX_WY_LO: begin
          s_next.wr.y[7:0] = wbyte;
        end
        `CER_IDX_WY_HI: begin
          s_next.wr.y[15:8] = wbyte;
        end
        default: begin
          s_next.e2p = s_next.e2p;             // read coordinates are read-only
        end
      endcase
    end

    // eeprom update is only acknowledged while accepted; the bit then
    // clears itself, so every update needs a fresh permission
    if (ee_load_req && s_reg.e2p[`CER_E2P_SYNC]) begin
      s_next.load_ack            = 1'b1;
      if (!e2p_wr) begin
        s_next.e2p[`CER_E2P_SYNC] = 1'b0;
      end
    end

    // index transfer sequencer; self-clear comes after any host write above
    case (s_reg.seq)
      CER_IDLE: begin
        s_next.cnt = s_next.cnt;
      end
      // the store takes the write coordinates at this edge
      CER_WR: begin
        s_next.pdc[`CER_PDC_WRIDX] = 1'b0;
        s_next.seq = CER_IDLE;
      end
      // read data of the store is registered: wait one cycle
      CER_RD: begin
        s_next.seq = CER_RD_LD;
      end
      // read data now stands; load it into the read coordinates
      CER_RD_LD: begin
        s_next.rd = mem_rdata;
        s_next.pdc[`CER_PDC_RDIDX] = 1'b0;
        s_next.seq = CER_IDLE;
      end
      // fetch the next record; the registered read needs this cycle
      CER_SV_RD: begin
        s_next.seq = CER_SV_OUT;
      end
      // hold the record until the eeprom writer takes it
      CER_SV_OUT: begin
        if (ee_save_ready) begin
          if (s_reg.cnt == `CER_LAST_INDEX) begin
            s_next.pdc[`CER_PDC_SAVE] = 1'b0;
            if (!e2p_wr) begin
              s_next.e2p[`CER_E2P_WREN] = 1'b0;
            end
            s_next.seq = CER_IDLE;
          end else begin
            s_next.cnt = s_reg.cnt + 4'h1;
            s_next.seq = CER_SV_RD;
          end
        end
      end
      default: begin
        s_next.seq = CER_IDLE;
      end
    endcase

    // video path: one cycle of latency
    s_next.pix.valid = pix_in.valid;
    s_next.pix.data  = effect_pix(pix_in.data, s_reg.effect);
  end

  // all bank state, reset to the initial register values
  // the coordinate store is left out: it needs no reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg        <= '0;
      s_reg.effect <= `CER_RST_EFFECT;
      s_reg.e2p    <= `CER_RST_EEPROM;
      s_reg.strobe_active_time   <= `CER_RST_STROBE_ACTIVE_TIME;
      s_reg.pdc    <= `CER_RST_PDC;
      s_reg.seq    <= CER_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // coordinate store
  cer_index_mem #(
    .DEPTH (16)
  ) u_mem (
    .pclk  (pclk),
    .we    (mem_we),
    .waddr (s_reg.idx),
    .wdata (s_reg.wr),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  // strobe pulse timing
  cer_strobe_timer #(
    .CYC_PER_US (`CER_CYC_PER_US)
  ) u_strobe (
    .pclk      (pclk),
    .presetn   (presetn),
    .trig_pin  (strobe_trig),
    .active_us (s_reg.strobe_active_time),
    .strobe    (strobe)
  );

  // outputs
  assign apb_rsp.prdata  = s_reg.prdata;
  assign apb_rsp.pready  = 1'b1;           // zero wait states
  assign apb_rsp.pslverr = access && s_reg.pslverr;

  // video and control levels straight from the bank registers
  assign pix_out         = s_reg.pix;
  assign pdc_enable      = s_reg.pdc[`CER_PDC_EN];
  assign pdc_marker_show = s_reg.pdc[`CER_PDC_SHOW];
  assign ee_write_en     = s_reg.e2p[`CER_E2P_WREN];
  assign ee_sync_en      = s_reg.e2p[`CER_E2P_SYNC];
  assign ee_load_ack     = s_reg.load_ack;

  // save stream: valid decoded from the state, record from flops
  assign ee_save.valid   = (s_reg.seq == CER_SV_OUT);
  assign ee_save.index   = s_reg.cnt;
  assign ee_save.coord   = mem_rdata;

endmodule
`default_nettype wire

/* File: cer_regs_props.sv */
// concurrent checks on the camera effect register bank ports
`timescale 1ns/1ns
`default_nettype none

module cer_regs_props (
  // clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // apb
  input wire cer_pkg::cer_apb_req_t apb_req,
  input wire cer_pkg::cer_apb_rsp_t apb_rsp,
  // video
  input wire cer_pkg::cer_pix_t     pix_in,
  input wire cer_pkg::cer_pix_t     pix_out,
  // controls and eeprom side
  input wire logic                  pdc_enable,
  input wire logic                  ee_write_en,
  input wire logic                  ee_sync_en,
  input wire logic                  ee_load_req,
  input wire logic                  ee_load_ack,
  input wire cer_pkg::cer_save_t    ee_save,
  input wire logic                  ee_save_ready,
  input wire logic                  strobe
);
  import cer_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // accepted write, qualified by the access phase
  logic acc_w;
  assign acc_w = apb_req.psel && apb_req.penable && apb_req.pwrite;

  property p_ready;
    apb_req.psel && apb_req.penable |-> apb_rsp.pready;
  endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  property p_err;
    apb_req.psel && apb_req.penable && apb_req.paddr[1:0] != 2'h0 |-> apb_rsp.pslverr;
  endproperty
  a_err: assert property (p_err) else $error("misaligned access not refused");
  property p_pdc_en;
    acc_w && apb_req.paddr == 12'h280 |=> pdc_enable == $past(apb_req.pwdata[0]);
  endproperty
  a_pdc_en: assert property (p_pdc_en) else $error("correction enable wrong");
  property p_wren;
    acc_w && apb_req.paddr == 12'h200 |=> ee_write_en == $past(apb_req.pwdata[0]);
  endproperty
  a_wren: assert property (p_wren) else $error("eeprom write permit wrong");
  property p_ack;
    ee_load_req && ee_sync_en |=>
      ee_load_ack && (!ee_sync_en || $past(acc_w && apb_req.paddr == 12'h200));
  endproperty
  a_ack: assert property (p_ack) else $error("update not taken");
  property p_noack;
    !ee_sync_en |=> !ee_load_ack;
  endproperty
  a_noack: assert property (p_noack) else $error("update taken while refused");
  property p_stall;
    ee_save.valid && !ee_save_ready |=> ee_save.valid && $stable(ee_save.index);
  endproperty
  a_stall: assert property (p_stall) else $error("save record dropped");
  property p_save_gate;
    $rose(ee_save.valid) |-> ee_write_en;
  endproperty
  a_save_gate: assert property (p_save_gate) else $error("save without permit");
  property p_pix;
    pix_in.valid |=> pix_out.valid;
  endproperty
  a_pix: assert property (p_pix) else $error("pixel lost");
  property p_strobe_active_time;
    $rose(strobe) |-> strobe [*8];
  endproperty
  a_strobe_active_time: assert property (p_strobe_active_time) else $error("strobe too short");
endmodule

bind cer_regs cer_regs_props u_props (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .pix_in(pix_in), .pix_out(pix_out), .pdc_enable(pdc_enable),
  .ee_write_en(ee_write_en), .ee_sync_en(ee_sync_en), .ee_load_req(ee_load_req),
  .ee_load_ack(ee_load_ack), .ee_save(ee_save), .ee_save_ready(ee_save_ready),
  .strobe(strobe)
);
`default_nettype wire

/* File: cer_regs_tb.sv */
// self-checking bench for the camera effect register bank
`timescale 1ns/1ns
`default_nettype none

module cer_regs_tb;
  import cer_pkg::*;
  logic         pclk;
  logic         presetn;
  cer_apb_req_t req;
  cer_apb_rsp_t rsp;
  cer_pix_t     pin;
  cer_pix_t     pout;
  logic         pdc_en;
  logic         mshow;
  logic         wr_en;
  logic         sync_en;
  logic         load_req;
  logic         load_ack;
  cer_save_t    save;
  logic         save_rdy;
  logic         trig;
  logic         strobe_active_time;
  int           rec_cnt;
  int           bad_cnt;
  int           ack_cnt;
  int           error_cnt;
  int           n_compared;
  int           n;
  logic [31:0]  rd;
  logic         err;
  logic [11:0]  pexp;
  logic [31:0]  coord5;
  localparam logic [11:0] RA [15] = '{12'h1E4, 12'h200, 12'h250, 12'h254, 12'h258,
    12'h280, 12'h284, 12'h288, 12'h28C, 12'h290, 12'h294, 12'h298, 12'h29C, 12'h2A0, 12'h2A4};
  localparam logic [7:0] CV [4] = '{8'h34, 8'h12, 8'h78, 8'h06};

  cer_regs dut (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .pix_in(pin),
    .pix_out(pout), .pdc_enable(pdc_en), .pdc_marker_show(mshow), .ee_write_en(wr_en),
    .ee_sync_en(sync_en), .ee_load_req(load_req), .ee_load_ack(load_ack), .ee_save(save),
    .ee_save_ready(save_rdy), .strobe_trig(trig), .strobe(strobe_active_time)
  );
  cer_ee_model ee (
    .pclk(pclk), .presetn(presetn), .ee_save(save), .ee_save_ready(save_rdy),
    .rec_cnt(rec_cnt), .bad_cnt(bad_cnt)
  );

  // clock, update acknowledge counter and capture of the index 5 record
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (load_ack === 1'b1) ack_cnt++;
    if (save.valid === 1'b1 && save_rdy === 1'b1 && save.index == 4'h5) coord5 <= save.coord;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one apb transfer; waits for ready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int i;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, {24'h000000, d}};
    @(posedge pclk);
    req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (rsp.pready !== 1'b1 && i < 20);
    if (rsp.pready !== 1'b1) begin
      error_cnt++;
      final_report();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, e);
  endtask

  task automatic pulse_load;
    @(posedge pclk);
    load_req <= 1'b1;
    @(posedge pclk);
    load_req <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  initial begin
    req = '0;
    pin = '{1'b1, 12'hA5C};
    load_req = 1'b0;
    trig = 1'b0;
    ack_cnt = 0;
    error_cnt = 0;
    n_compared = 0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, unmapped and read-only places
    foreach (RA[k]) rdc(RA[k], 32'h0);
    apb(1'b0, 12'h004, 8'h00);
    chk(32'(err), 32'h1);
    apb(1'b0, 12'h201, 8'h00);
    chk(32'(err), 32'h1);
    wr(12'h298, 8'h55);
    rdc(12'h298, 32'h0);
    $display("test reset done");
    // strobe time bytes and index width
    wr(12'h254, 8'hA5);
    wr(12'h258, 8'h5A);
    wr(12'h250, 8'h02);
    rdc(12'h254, 32'hA5);
    rdc(12'h258, 32'h5A);
    wr(12'h254, 8'h00);
    wr(12'h258, 8'h00);
    wr(12'h284, 8'hF5);
    rdc(12'h284, 32'h05);
    $display("test fields done");
    // every effect code, positive then negative; codes stay legal
    for (int c = 0; c < 24; c++) begin
      wr(12'h1E4, {c >= 12, 7'(c % 12)});
      pexp = 12'hA5C & (12'hFFF << (c % 12));
      if (c >= 12) pexp = ~pexp;
      repeat (2) @(posedge pclk);
      chk(32'(pout.data), 32'(pexp));
    end
    wr(12'h1E4, 8'h00);
    $display("test effect done");
    // store index 5, clobber write coordinates, load it back
    foreach (CV[k]) wr(12'h288 + 12'(4 * k), CV[k]);
    wr(12'h280, 8'h83);
    foreach (CV[k]) wr(12'h288 + 12'(4 * k), 8'h00);
    chk(32'(pdc_en), 32'h1);
    chk(32'(mshow), 32'h1);
    rdc(12'h280, 32'h03);
    wr(12'h280, 8'h41);
    repeat (3) @(posedge pclk);
    rdc(12'h280, 32'h01);
    foreach (CV[k]) rdc(12'h298 + 12'(4 * k), 32'(CV[k]));
    $display("test index done");
    // save refused without permit, then sixteen records
    wr(12'h280, 8'h20);
    repeat (4) @(posedge pclk);
    rdc(12'h280, 32'h0);
    chk(rec_cnt, 0);
    wr(12'h200, 8'h01);
    wr(12'h280, 8'h21);
    wr(12'h280, 8'h61);
    n = 0;
    do begin
      apb(1'b0, 12'h280, 8'h00);
      n++;
    end while (rd[5] !== 1'b0 && n < 100);
    if (rd[5] !== 1'b0) begin
      error_cnt++;
      final_report();
    end
    chk(rd, 32'h01);
    chk(rec_cnt, 16);
    chk(bad_cnt, 0);
    chk(coord5, {16'h1234, 16'h0678});
    chk(32'(wr_en), 32'h0);
    $display("test save done");
    // register update refused, accepted once, then refused again
    pulse_load();
    chk(ack_cnt, 0);
    wr(12'h200, 8'h02);
    pulse_load();
    chk(ack_cnt, 1);
    rdc(12'h200, 32'h0);
    pulse_load();
    chk(ack_cnt, 1);
    $display("test update done");
    // strobe of two microseconds at 100 cycles each
    trig <= 1'b1;
    for (n = 0; n < 10 && strobe_active_time !== 1'b1; n++) @(posedge pclk);
    if (strobe_active_time !== 1'b1) begin
      error_cnt++;
      final_report();
    end
    n = 0;
    while (strobe_active_time === 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n >= 200 && n <= 201), 32'h1);
    trig <= 1'b0;
    $display("test strobe done");
    final_report();
  end
endmodule
`default_nettype wire

/* File: cer_strobe_timer.sv */
// strobe pulse generator counting whole microseconds
`timescale 1ns/1ns
`default_nettype none
`include "cer_defs.svh"

module cer_strobe_timer #(
  parameter int CYC_PER_US = `CER_CYC_PER_US
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // trigger pin and programmed time
  input  wire logic        trig_pin,
  input  wire logic [23:0] active_us,
  // strobe output
  output logic             strobe
);
  import cer_pkg::*;

  localparam logic [6:0] PRE_LAST = 7'(CYC_PER_US - 1);

  cer_strobe_active_time_state_t s_reg;
  cer_strobe_active_time_state_t s_next;

  // sync the pin, then time the pulse; a retrigger during a pulse is ignored
  always_comb begin
    s_next       = s_reg;
    s_next.sync1 = trig_pin;
    s_next.sync2 = s_reg.sync1;
    s_next.prev  = s_reg.sync2;
    if (s_reg.left != 24'h000000) begin
      if (s_reg.pre == 7'h00) begin
        s_next.pre  = PRE_LAST;
        s_next.left = s_reg.left - 24'h000001;
      end else begin
        s_next.pre = s_reg.pre - 7'h01;
      end
    end else if (s_reg.sync2 && !s_reg.prev) begin
      s_next.left = active_us;
      s_next.pre  = PRE_LAST;
    end
    s_next.strobe = (s_next.left != 24'h000000);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign strobe = s_reg.strobe;

endmodule
`default_nettype wire
